//--- rtl/adc_serial_power_control_regs.svh
// Constants for the serial conversion and power control block.
`ifndef ADC_SERIAL_POWER_CONTROL_REGS_SVH
`define ADC_SERIAL_POWER_CONTROL_REGS_SVH
`define FRAME_BITS 16
`define TRACK_EDGE 14
`define CTRL_RESET 16'h0000
`define WRITE_BIT_POS 15
`define REPEAT_BIT_POS 14
`define CH_MSB_POS 13
`define CH_LSB_POS 6
`define PARTIAL_SLEEP_BIT_POS 4
`define ALL_ONES_WORD 16'hFFFF
`define CLK_PERIOD_NS 25
`define PULSE_LIMIT_NS 100
`define PULSE_LIMIT_CYC ((`PULSE_LIMIT_NS) / (`CLK_PERIOD_NS))
`define IFACE_DELAY_US 500
`define IFACE_DELAY_CYC (((`IFACE_DELAY_US) * 1000) / (`CLK_PERIOD_NS))
`define REF_SETTLE_MS 6
`define REF_SETTLE_CYC (((`REF_SETTLE_MS) * 1000000) / (`CLK_PERIOD_NS))
`endif

//--- rtl/adc_serial_power_control_pkg.sv
// Types shared by the serial conversion and power control block.
package adc_serial_power_control_pkg;
	typedef enum logic [1:0] {
		pwr_normal,
		pwr_partial,
		pwr_full
	} power_e;
	typedef struct packed {
		logic [3:0] result_channel_tag;
		logic [11:0] result;
	} out_word_s;
	typedef struct packed {
		logic tracking;
		logic partial_sleep;
		logic full_sleep;
		logic iface_ready;
		logic ref_ready;
		logic convert_start;
		logic [2:0] convert_channel;
	} status_s;
endpackage : adc_serial_power_control_pkg

//--- rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter.
module pin_sync
#(
	parameter logic IDLE = 1'b0
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rstn,
	// Pin in and filtered level out.
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1 <= IDLE;
			s2 <= IDLE;
			s3 <= IDLE;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			level <= IDLE;
		else if (s2 == s3)
			level <= s3;
	end
endmodule : pin_sync

//--- rtl/adc_serial_power_control.sv
// Serial frame, control register and power-down control of the converter.
module adc_serial_power_control
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rstn,
	// Serial link pins.
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// Power-down and reset pin, active low.
	input wire logic powerdown_reset_pin_n,
	// Conversion result from the analog core.
	input wire logic [11:0] conv_result,
	// Status towards the analog core.
	output adc_serial_power_control_pkg::status_s status,
	output logic [15:0] control_word
);
`include "adc_serial_power_control_regs.svh"
	localparam logic [7:0] PULSE_CYC = 8'(`PULSE_LIMIT_CYC);
	localparam logic [23:0] IFACE_CYC = 24'(`IFACE_DELAY_CYC);
	localparam logic [23:0] REF_CYC = 24'(`REF_SETTLE_CYC);
	// ============================================================
	// Input synchronisers.
	logic cs_n_s;
	logic sclk_s;
	logic din_s;
	logic pd_s;
	pin_sync #(.IDLE(1'b1)) u_cs (.sys_clk(sys_clk), .rstn(rstn), .pin(cs_n),
		.level(cs_n_s));
	pin_sync #(.IDLE(1'b1)) u_sclk (.sys_clk(sys_clk), .rstn(rstn), .pin(sclk),
		.level(sclk_s));
	pin_sync u_din (.sys_clk(sys_clk), .rstn(rstn), .pin(din), .level(din_s));
	pin_sync #(.IDLE(1'b1)) u_pd (.sys_clk(sys_clk), .rstn(rstn), .pin(powerdown_reset_pin_n),
		.level(pd_s));
	logic cs_d;
	logic sclk_d;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cs_d <= 1'b1;
			sclk_d <= 1'b1;
		end
		else
		begin
			cs_d <= cs_n_s;
			sclk_d <= sclk_s;
		end
	end
	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	assign cs_fall = cs_d & ~cs_n_s;
	assign cs_rise = ~cs_d & cs_n_s;
	assign sclk_fall = sclk_d & ~sclk_s & ~cs_n_s;
	// ============================================================
	// Power-down pin: short pulse resets, long low powers down.
	logic [7:0] low_cnt;
	logic pd_d;
	logic soft_reset;
	logic full_sleep;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			low_cnt <= 8'h00;
			pd_d <= 1'b1;
		end
		else
		begin
			pd_d <= pd_s;
			if (pd_s)
				low_cnt <= 8'h00;
			else if (low_cnt <= PULSE_CYC)
				low_cnt <= low_cnt + 8'h01;
		end
	end
	assign full_sleep = ~pd_s & (low_cnt > PULSE_CYC);
	assign soft_reset = ~pd_d & pd_s;
	logic clear_all;
	assign clear_all = ~pd_s | soft_reset;
	// ============================================================
	// Start-up timers for interface and internal reference.
	logic [23:0] iface_cnt;
	logic [23:0] ref_cnt;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			iface_cnt <= 24'h00_0000;
			ref_cnt <= 24'h00_0000;
		end
		else if (full_sleep)
		begin
			iface_cnt <= 24'h00_0000;
			ref_cnt <= 24'h00_0000;
		end
		else
		begin
			if (iface_cnt < IFACE_CYC)
				iface_cnt <= iface_cnt + 24'h00_0001;
			if (ref_cnt < REF_CYC)
				ref_cnt <= ref_cnt + 24'h00_0001;
		end
	end
	// ============================================================
	// Frame counter and shift registers.
	logic [4:0] edge_cnt;
	logic [15:0] in_shift;
	logic [15:0] out_shift;
	logic in_frame;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			edge_cnt <= 5'h00;
		else if (clear_all || cs_fall)
			edge_cnt <= 5'h00;
		else if (sclk_fall && edge_cnt < 5'(`FRAME_BITS))
			edge_cnt <= edge_cnt + 5'h01;
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			in_frame <= 1'b0;
		else if (clear_all || cs_rise)
			in_frame <= 1'b0;
		else if (cs_fall)
			in_frame <= 1'b1;
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			in_shift <= 16'h0000;
		else if (sclk_fall && edge_cnt < 5'(`FRAME_BITS))
			in_shift <= {in_shift[14:0], din_s};
	end
	// ============================================================
	// Control register and power state.
	logic [15:0] ctrl;
	adc_serial_power_control_pkg::power_e pstate;
	logic write_done;
	assign write_done = cs_rise && in_frame && edge_cnt == 5'(`FRAME_BITS)
		&& in_shift[`WRITE_BIT_POS];
	// Writes before the interface is ready are ignored.
	logic write_ok;
	assign write_ok = write_done && iface_cnt >= IFACE_CYC;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			ctrl <= `CTRL_RESET;
		else if (clear_all)
			ctrl <= `CTRL_RESET;
		else if (write_ok)
			ctrl <= in_shift;
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			pstate <= adc_serial_power_control_pkg::pwr_normal;
		else if (full_sleep)
			pstate <= adc_serial_power_control_pkg::pwr_full;
		else if (clear_all)
			pstate <= adc_serial_power_control_pkg::pwr_normal;
		else
		begin
			case (pstate)
				adc_serial_power_control_pkg::pwr_normal:
					if (write_ok && in_shift[`PARTIAL_SLEEP_BIT_POS])
						pstate <= adc_serial_power_control_pkg::pwr_partial;
				adc_serial_power_control_pkg::pwr_partial:
					if (write_ok && !in_shift[`PARTIAL_SLEEP_BIT_POS])
						pstate <= adc_serial_power_control_pkg::pwr_normal;
				adc_serial_power_control_pkg::pwr_full:
					pstate <= adc_serial_power_control_pkg::pwr_normal;
				default:
					pstate <= adc_serial_power_control_pkg::pwr_normal;
			endcase
		end
	end
	// ============================================================
	// Channel selection: lowest selected channel in ascending order.
	logic [7:0] ch_mask;
	logic [7:0] done_mask;
	logic [7:0] pend;
	logic [2:0] next_ch;
	logic have_ch;
	logic wrap;
	assign ch_mask = ctrl[`CH_MSB_POS:`CH_LSB_POS];
	assign pend = ch_mask & ~done_mask;
	// Repeat mode starts the sequence again once every channel is done.
	assign wrap = pend == 8'h00 && ctrl[`REPEAT_BIT_POS];
	always_comb
	begin
		next_ch = 3'h0;
		have_ch = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			if (wrap ? ch_mask[i] : pend[i])
			begin
				next_ch = 3'(i);
				have_ch = 1'b1;
			end
		end
	end
	logic conv_valid;
	logic conv_pending;
	logic [2:0] conv_ch;
	logic [3:0] last_tag;
	logic [11:0] last_result;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			done_mask <= 8'h00;
			conv_valid <= 1'b0;
			conv_pending <= 1'b0;
			conv_ch <= 3'h0;
			last_tag <= 4'h0;
			last_result <= 12'h000;
		end
		else if (clear_all || write_ok)
		begin
			done_mask <= 8'h00;
			conv_valid <= 1'b0;
			conv_pending <= 1'b0;
		end
		else
		begin
			if (cs_fall)
			begin
				conv_pending <= pstate == adc_serial_power_control_pkg::pwr_normal && have_ch;
				conv_ch <= next_ch;
				if (have_ch && pstate == adc_serial_power_control_pkg::pwr_normal)
					done_mask <= (wrap ? 8'h00 : done_mask) | (8'h01 << next_ch);
			end
			if (cs_rise && in_frame)
			begin
				conv_valid <= conv_pending && edge_cnt == 5'(`FRAME_BITS);
				conv_pending <= 1'b0;
				if (conv_pending && edge_cnt == 5'(`FRAME_BITS))
				begin
					last_tag <= {1'b0, conv_ch};
					last_result <= conv_result;
				end
			end
		end
	end
	// ============================================================
	// Output word and data pin driver.
	adc_serial_power_control_pkg::out_word_s word;
	always_comb
	begin
		word.result_channel_tag = last_tag;
		word.result = last_result;
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			out_shift <= `ALL_ONES_WORD;
		else if (cs_fall)
		begin
			if (pstate != adc_serial_power_control_pkg::pwr_normal || !conv_valid)
				out_shift <= `ALL_ONES_WORD;
			else
				out_shift <= word;
		end
		else if (sclk_fall)
			out_shift <= {out_shift[14:0], 1'b1};
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dout <= 1'b1;
			dout_oe <= 1'b0;
		end
		else
		begin
			if (cs_fall)
				dout <= (pstate != adc_serial_power_control_pkg::pwr_normal || !conv_valid)
					? 1'b1 : word[15];
			else if (sclk_fall)
				dout <= out_shift[14];
			if (clear_all || cs_rise)
				dout_oe <= 1'b0;
			else if (cs_fall && pstate != adc_serial_power_control_pkg::pwr_full)
				dout_oe <= 1'b1;
			else if (sclk_fall && edge_cnt == 5'(`FRAME_BITS - 1))
				dout_oe <= 1'b0;
		end
	end
	// ============================================================
	// Status outputs.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			status <= '0;
			control_word <= `CTRL_RESET;
		end
		else
		begin
			status.tracking <= !in_frame || edge_cnt >= 5'(`TRACK_EDGE);
			status.partial_sleep <= pstate == adc_serial_power_control_pkg::pwr_partial;
			status.full_sleep <= full_sleep;
			status.iface_ready <= iface_cnt >= IFACE_CYC;
			status.ref_ready <= ref_cnt >= REF_CYC;
			status.convert_start <= cs_fall && pstate == adc_serial_power_control_pkg::pwr_normal;
			status.convert_channel <= next_ch;
			control_word <= ctrl;
		end
	end
endmodule : adc_serial_power_control

//--- verification/adc_serial_power_control_checker.sv
// Checker of the serial frame and power-down behaviour.
module adc_serial_power_control_checker
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rstn,
	// Pins and status.
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic powerdown_reset_pin_n,
	input wire adc_serial_power_control_pkg::status_s status,
	input wire logic [15:0] control_word
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====
	// Idle counter.
	logic [3:0] idle;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			idle <= 4'h0;
		else if (!cs_n)
			idle <= 4'h0;
		else if (idle != 4'hf)
			idle <= idle + 4'h1;
	end
	// ====
	// Serial clock falls seen at the pin within the current frame.
	logic sclk_q;
	logic [4:0] falls;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclk_q <= 1'b1;
			falls <= 5'h00;
		end
		else
		begin
			sclk_q <= sclk;
			if (cs_n)
				falls <= 5'h00;
			else if (sclk_q && !sclk && falls != 5'h1f)
				falls <= falls + 5'h01;
		end
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	a_oe_idle_off: assert property (idle >= 4'h8 |-> !dout_oe)
		else $error("output driven while idle");
	a_oe_on_select: assert property ($fell(cs_n) && status.iface_ready |-> ##[1:8] dout_oe)
		else $error("output not driven");
	a_sleep_ones: assert property (status.partial_sleep && dout_oe |-> dout)
		else $error("sleep word not ones");
	a_ctrl_idle_only: assert property (!$stable(control_word) |-> cs_n)
		else $error("control changed in frame");
	a_sleep_enter: assert property ($rose(control_word[4]) |-> ##[0:3] status.partial_sleep)
		else $error("partial sleep not entered");
	a_sleep_exit: assert property ($fell(control_word[4]) |-> ##[0:3] !status.partial_sleep)
		else $error("partial sleep not left");
	a_full_enter: assert property (!powerdown_reset_pin_n [*8] |-> ##[0:4] status.full_sleep)
		else $error("full sleep not entered");
	a_full_clears: assert property (status.full_sleep |-> control_word == 16'h0000)
		else $error("control kept in full sleep");
	a_short_pulse: assert property (powerdown_reset_pin_n ##1 !powerdown_reset_pin_n [*2]
		##1 powerdown_reset_pin_n |-> !status.full_sleep [*8])
		else $error("short pulse slept");
	a_track_held: assert property (!cs_n && falls != 5'h00 && falls < 5'h0e |-> !status.tracking)
		else $error("sampler tracking too early");
	a_track_back: assert property (!cs_n && falls >= 5'h0f |-> status.tracking)
		else $error("sampler not tracking again");
	c_partial: cover property ($rose(status.partial_sleep));
	c_full: cover property ($rose(status.full_sleep));
	c_convert: cover property (status.convert_start);
endmodule : adc_serial_power_control_checker

bind adc_serial_power_control adc_serial_power_control_checker chk (.sys_clk(sys_clk),
	.rstn(rstn), .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe(dout_oe),
	.powerdown_reset_pin_n(powerdown_reset_pin_n), .status(status),
	.control_word(control_word));

//--- verification/serial_host_model.sv
// Host model that frames serial transfers towards the converter.
module serial_host_model
(
	// Clock.
	input wire logic sys_clk,
	// Serial pins.
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====
	// Frame task.
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end
	// Sends n clock falls, 200 ns period; oe holds enable just before the second fall and at end.
	task automatic xfer(input logic [15:0] wr, input int n, output logic [15:0] rd,
		output logic [1:0] oe);
		rd = 16'h0000;
		oe = 2'h0;
		cs_n <= 1'b0;
		din <= wr[15];
		repeat (8) @(posedge sys_clk);
		for (int i = 0; i < n; i++)
		begin
			rd[15 - i] = dout;
			if (i == 1)
				oe[1] = dout_oe;
			sclk <= 1'b0;
			repeat (4) @(posedge sys_clk);
			sclk <= 1'b1;
			din <= (i < 15) ? wr[14 - i] : !wr[0];
			repeat (4) @(posedge sys_clk);
		end
		oe[0] = dout_oe;
		cs_n <= 1'b1;
		din <= !din;
		repeat (16) @(posedge sys_clk);
	endtask : xfer
endmodule : serial_host_model

//--- verification/adc_serial_power_control_bench.sv
// Self-checking bench for the serial conversion and power control block.
module adc_serial_power_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	// ====
	// Bench.
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic powerdown_reset_pin_n = 1'b1;
	logic [11:0] conv_result = 12'h000;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe;
	adc_serial_power_control_pkg::status_s status;
	logic [15:0] control_word;
	logic [15:0] rd;
	logic [1:0] oe;
	int miscompares = 0;
	int tests_run = 0;
	always #12.5 sys_clk = ~sys_clk;
	adc_serial_power_control adc_serial_power_control_inst (.sys_clk(sys_clk), .rstn(rstn),
		.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
		.powerdown_reset_pin_n(powerdown_reset_pin_n), .conv_result(conv_result),
		.status(status), .control_word(control_word));
	serial_host_model serial_host_model_inst (.sys_clk(sys_clk), .cs_n(cs_n),
		.sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic fr(input logic [15:0] w);
		serial_host_model_inst.xfer(w, 16, rd, oe);
	endtask : fr
	task automatic wait_ready();
		int k;
		for (k = 0; k < 25000 && status.iface_ready !== 1'b1; k++)
			@(posedge sys_clk);
		if (k == 25000)
		begin
			miscompares++;
			final_report();
		end
	endtask : wait_ready
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		check("ctrl", control_word, 16'h0000);
		fr(16'h8100);
		check("early", control_word, 16'h0000);
		wait_ready();
		check("ref", {15'h0, status.ref_ready}, 16'h0000);
		fr(16'h8100);
		check("write", control_word, 16'h8100);
		check("next", {13'h0, status.convert_channel}, 16'h0002);
		check("oe", {14'h0, oe}, 16'h0002);
		conv_result <= 12'ha5c;
		fr(16'h0000);
		check("nowrite", control_word, 16'h8100);
		conv_result <= 12'h3c1;
		fr(16'h0000);
		check("word", rd, 16'h2a5c);
		serial_host_model_inst.xfer(16'h8200, 8, rd, oe);
		check("abort", control_word, 16'h8100);
		$display("test frames done");
		fr(16'h8110);
		check("sleep", {15'h0, status.partial_sleep}, 16'h0001);
		fr(16'h0000);
		check("ones", rd, 16'hffff);
		check("stay", {15'h0, status.partial_sleep}, 16'h0001);
		fr(16'h8100);
		check("wake", {15'h0, status.partial_sleep}, 16'h0000);
		fr(16'h8100);
		conv_result <= 12'h5a5;
		fr(16'h0000);
		conv_result <= 12'h000;
		fr(16'h0000);
		check("fourth", rd, 16'h25a5);
		$display("test partial done");
		powerdown_reset_pin_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		powerdown_reset_pin_n <= 1'b1;
		repeat (16) @(posedge sys_clk);
		check("pulse", control_word, 16'h0000);
		check("nofull", {15'h0, status.full_sleep}, 16'h0000);
		wait_ready();
		fr(16'h8100);
		powerdown_reset_pin_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		check("full", {15'h0, status.full_sleep}, 16'h0001);
		check("lost", control_word, 16'h0000);
		powerdown_reset_pin_n <= 1'b1;
		repeat (16) @(posedge sys_clk);
		check("up", {15'h0, status.full_sleep}, 16'h0000);
		$display("test pin done");
		wait_ready();
		fr(16'hc280);
		check("seq", control_word, 16'hc280);
		conv_result <= 12'h111;
		fr(16'h0000);
		conv_result <= 12'h333;
		fr(16'h0000);
		check("first", rd, 16'h1111);
		conv_result <= 12'h555;
		fr(16'h0000);
		check("second", rd, 16'h3333);
		fr(16'h0000);
		check("wrap", rd, 16'h1555);
		$display("test sequence done");
		final_report();
	end
endmodule : adc_serial_power_control_bench
